// File: logic/idst_pkg.sv
// constants for the slave drive timing block
package idst_pkg;
	localparam logic [7:0] IDST_SLAVE_TIMING_OFS = 8'h44;
	localparam logic [7:0] IDST_SLAVE_TIMING_RST = 8'h00;
	localparam int IDST_SEC_ISP_LSB = 6;
	localparam int IDST_SEC_RTC_LSB = 4;
	localparam int IDST_PRI_ISP_LSB = 2;
	localparam int IDST_PRI_RTC_LSB = 0;
	localparam logic [2:0] IDST_ISP_BASE = 3'h5;
	localparam logic [2:0] IDST_RTC_BASE = 3'h4;
	localparam int IDST_DRIVE_SEL_BIT = 4;
	localparam logic [2:0] IDST_DRVHEAD_OFS = 3'h6;
	localparam logic [2:0] IDST_CNT_ZERO = 3'h0;
	localparam logic [2:0] IDST_CNT_ONE = 3'h1;
endpackage : idst_pkg

// File: logic/idst_channel.sv
// one channel's strobe, sample point and recovery sequencer
`timescale 1ns/1ns
`default_nettype none
module idst_channel
	import idst_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_start,
	input wire logic [2:0] i_isp_clks,
	input wire logic [2:0] i_rtc_clks,
	input wire logic i_iordy,
	output logic o_strobe_n,
	output logic o_sample,
	output logic o_busy
);
	typedef enum logic [1:0] {IDST_IDLE, IDST_WAIT, IDST_READY, IDST_RECOV} idst_state_e;
	idst_state_e state_q, state_d;
	logic [2:0] cnt_q, cnt_d;
	logic [2:0] rtc_q, rtc_d;
	wire logic cnt_done = (cnt_q == IDST_CNT_ONE);
	wire logic sample_pt = (state_q == IDST_WAIT) && cnt_done;
	wire logic sample_hit = (state_q == IDST_READY) || sample_pt;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		rtc_d = rtc_q;
		case (state_q)
			IDST_IDLE: begin
				if (i_start) begin
					state_d = IDST_WAIT;
					cnt_d = i_isp_clks; // RQ8
					rtc_d = i_rtc_clks;
				end
			end
			IDST_WAIT: begin
				// ready is judged at the sample point itself, not a cycle later
				if (cnt_done && i_iordy) begin
					state_d = IDST_RECOV;
					cnt_d = rtc_q; // RQ8
				end else if (cnt_done) state_d = IDST_READY;
				else cnt_d = cnt_q - IDST_CNT_ONE; // RQ8
			end
			IDST_READY: begin
				if (i_iordy) begin
					state_d = IDST_RECOV;
					cnt_d = rtc_q; // RQ8
				end
			end
			IDST_RECOV: begin
				if (cnt_done) state_d = IDST_IDLE;
				else cnt_d = cnt_q - IDST_CNT_ONE;
			end
			default: state_d = IDST_IDLE;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			state_q <= IDST_IDLE;
			cnt_q <= IDST_CNT_ZERO;
			rtc_q <= IDST_CNT_ZERO;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			rtc_q <= rtc_d;
		end
	end

	assign o_strobe_n = !((state_q == IDST_WAIT) || (state_q == IDST_READY));
	assign o_sample = sample_hit;
	assign o_busy = (state_q != IDST_IDLE);
endmodule : idst_channel
`default_nettype wire

// File: logic/idst_top.sv
// slave drive timing register and two channel strobe sequencers
// Notes on behaviour
// [RQ1] Slave timing is used only when separate slave timing is enabled, else master timing.
// [RQ2] The slave timing register is at 44h, 8 bits, read/write, resetting to 00h.
// [RQ3] Bits 7:6 give the secondary slave sample point: 5,4,3,2 clocks.
// [RQ4] Bits 5:4 give the secondary slave recovery: 4,3,2,1 clocks.
// [RQ5] Bits 3:2 give the primary slave sample point: 5,4,3,2 clocks.
// [RQ6] Bits 1:0 give the primary slave recovery: 4,3,2,1 clocks.
// [RQ7] The addressed drive comes from a kept copy of bit 4 written to drive/head at 1x6h.
// [RQ8] Both delays count clock cycles, loaded from the chosen drive at each strobe start.
`timescale 1ns/1ns
`default_nettype none
module idst_top
	import idst_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_cfg_wr,
	input wire logic [7:0] i_cfg_addr,
	input wire logic [7:0] i_cfg_wdata,
	output logic [7:0] o_cfg_rdata,
	input wire logic i_separate_slave_timing_enable,
	input wire logic [1:0] i_pri_master_isp,
	input wire logic [1:0] i_pri_master_rtc,
	input wire logic [1:0] i_sec_master_isp,
	input wire logic [1:0] i_sec_master_rtc,
	input wire logic [1:0] i_io_start,
	input wire logic [1:0] i_io_write,
	input wire logic [2:0] i_io_addr,
	input wire logic [7:0] i_io_wdata,
	input wire logic [1:0] i_iordy,
	output logic [1:0] o_io_strobe_n,
	output logic [1:0] o_iordy_sample,
	output logic [1:0] o_busy,
	output logic [1:0] o_drive_sel
);
	logic [7:0] slave_drive_timing_q;
	logic [1:0] drive_sel_q;
	logic [1:0] strobe_n_q, sample_q, busy_q;
	logic [7:0] rdata_q;
	logic [1:0] ch_strobe_n, ch_sample, ch_busy;
	wire logic cfg_hit = (i_cfg_addr == IDST_SLAVE_TIMING_OFS); // RQ2
	wire logic [1:0] pri_sisp = slave_drive_timing_q[IDST_PRI_ISP_LSB +: 2]; // RQ5
	wire logic [1:0] pri_srtc = slave_drive_timing_q[IDST_PRI_RTC_LSB +: 2]; // RQ6
	wire logic [1:0] sec_sisp = slave_drive_timing_q[IDST_SEC_ISP_LSB +: 2]; // RQ3
	wire logic [1:0] sec_srtc = slave_drive_timing_q[IDST_SEC_RTC_LSB +: 2]; // RQ4
	wire logic [1:0] use_slave = drive_sel_q & {2{i_separate_slave_timing_enable}}; // RQ1 RQ7
	wire logic [1:0] sel_isp [2];
	wire logic [1:0] sel_rtc [2];
	assign sel_isp[0] = use_slave[0] ? pri_sisp : i_pri_master_isp;
	assign sel_rtc[0] = use_slave[0] ? pri_srtc : i_pri_master_rtc;
	assign sel_isp[1] = use_slave[1] ? sec_sisp : i_sec_master_isp;
	assign sel_rtc[1] = use_slave[1] ? sec_srtc : i_sec_master_rtc;

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			slave_drive_timing_q <= IDST_SLAVE_TIMING_RST;
			rdata_q <= IDST_SLAVE_TIMING_RST;
		end else begin
			if (i_cfg_wr && cfg_hit) slave_drive_timing_q <= i_cfg_wdata; // RQ2
			rdata_q <= cfg_hit ? slave_drive_timing_q : 8'h00;
		end
	end

	// drive/head writes on each channel keep that channel's drive select bit
	wire logic [1:0] dh_wr = i_io_write & {2{i_io_addr == IDST_DRVHEAD_OFS}}; // RQ7
	wire logic [1:0] dh_bit = {2{i_io_wdata[IDST_DRIVE_SEL_BIT]}};
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) drive_sel_q <= 2'h0;
		else drive_sel_q <= (drive_sel_q & ~dh_wr) | (dh_bit & dh_wr); // RQ7
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			// 00 gives base, each step one clock less
			idst_channel u_ch (
				.i_ref_clk(i_ref_clk),
				.i_resetn(i_resetn),
				.i_start(i_io_start[g]),
				.i_isp_clks(IDST_ISP_BASE - {1'b0, sel_isp[g]}), // RQ3 RQ5
				.i_rtc_clks(IDST_RTC_BASE - {1'b0, sel_rtc[g]}), // RQ4 RQ6
				.i_iordy(i_iordy[g]),
				.o_strobe_n(ch_strobe_n[g]),
				.o_sample(ch_sample[g]),
				.o_busy(ch_busy[g])
			);
		end
	endgenerate

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			strobe_n_q <= 2'h3;
			sample_q <= 2'h0;
			busy_q <= 2'h0;
		end else begin
			strobe_n_q <= ch_strobe_n;
			sample_q <= ch_sample;
			busy_q <= ch_busy;
		end
	end

	assign o_cfg_rdata = rdata_q;
	assign o_io_strobe_n = strobe_n_q;
	assign o_iordy_sample = sample_q;
	assign o_busy = busy_q;
	assign o_drive_sel = drive_sel_q;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);

	// register and read path
	reg_write_a: assert property (i_cfg_wr && cfg_hit // RQ2
		|=> slave_drive_timing_q == $past(i_cfg_wdata))
		else $error("timing register did not take write");
	reg_hold_a: assert property (!(i_cfg_wr && cfg_hit) |=> $stable(slave_drive_timing_q)) // RQ2
		else $error("timing register changed without write");
	rdata_a: assert property (1'b1 // RQ2
		|=> o_cfg_rdata == ($past(cfg_hit) ? $past(slave_drive_timing_q) : 8'h00))
		else $error("read data wrong");

	// timing selection
	master_only_a: assert property (!i_separate_slave_timing_enable // RQ1
		|-> sel_isp[0] == i_pri_master_isp && sel_rtc[1] == i_sec_master_rtc)
		else $error("slave timing used while disabled");
	master_rest_a: assert property (!i_separate_slave_timing_enable // RQ1
		|-> sel_isp[1] == i_sec_master_isp && sel_rtc[0] == i_pri_master_rtc)
		else $error("slave timing used while disabled");
	pri_slave_a: assert property (i_separate_slave_timing_enable && drive_sel_q[0] // RQ5 RQ6
		|-> sel_isp[0] == slave_drive_timing_q[3:2] && sel_rtc[0] == slave_drive_timing_q[1:0])
		else $error("primary slave fields not selected");
	sec_slave_a: assert property (i_separate_slave_timing_enable && drive_sel_q[1] // RQ3 RQ4
		|-> sel_isp[1] == slave_drive_timing_q[7:6] && sel_rtc[1] == slave_drive_timing_q[5:4])
		else $error("secondary slave fields not selected");
	pri_master_a: assert property (!drive_sel_q[0] // RQ7
		|-> sel_isp[0] == i_pri_master_isp && sel_rtc[0] == i_pri_master_rtc)
		else $error("primary master timing not selected");
	sec_master_a: assert property (!drive_sel_q[1] // RQ7
		|-> sel_isp[1] == i_sec_master_isp && sel_rtc[1] == i_sec_master_rtc)
		else $error("secondary master timing not selected");
	drv_copy_a: assert property (i_io_write[0] && i_io_addr == 3'h6 // RQ7
		|=> drive_sel_q[0] == $past(i_io_wdata[4]))
		else $error("drive select copy wrong");
	drv_copy1_a: assert property (i_io_write[1] && i_io_addr == 3'h6 // RQ7
		|=> drive_sel_q[1] == $past(i_io_wdata[4]))
		else $error("secondary drive select copy wrong");

	// sample point, counted from the start edge
	isp_five_a: assert property (i_io_start[0] && !ch_busy[0] && sel_isp[0] == 2'h0 // RQ5 RQ8
		|-> ##5 ch_sample[0])
		else $error("sample point not at five clocks");
	no_early_a: assert property (i_io_start[0] && !ch_busy[0] && sel_isp[0] == 2'h0 // RQ8
		|-> ##1 !ch_sample[0] [*4])
		else $error("sample point came early");
	isp_four_a: assert property (i_io_start[0] && !ch_busy[0] && sel_isp[0] == 2'h1 // RQ5
		|-> ##4 ch_sample[0])
		else $error("primary sample point not at four clocks");
	isp_three_a: assert property (i_io_start[0] && !ch_busy[0] && sel_isp[0] == 2'h2 // RQ5
		|-> ##3 ch_sample[0])
		else $error("primary sample point not at three clocks");
	pri_two_a: assert property (i_io_start[0] && !ch_busy[0] && sel_isp[0] == 2'h3 // RQ5
		|-> ##1 !ch_sample[0] ##1 ch_sample[0])
		else $error("primary sample point not at two clocks");
	sec_five_a: assert property (i_io_start[1] && !ch_busy[1] && sel_isp[1] == 2'h0 // RQ3
		|-> ##5 ch_sample[1])
		else $error("secondary sample point not at five clocks");
	sec_four_a: assert property (i_io_start[1] && !ch_busy[1] && sel_isp[1] == 2'h1 // RQ3
		|-> ##4 ch_sample[1])
		else $error("secondary sample point not at four clocks");
	sec_three_a: assert property (i_io_start[1] && !ch_busy[1] && sel_isp[1] == 2'h2 // RQ3
		|-> ##3 ch_sample[1])
		else $error("secondary sample point not at three clocks");
	isp_two_a: assert property (i_io_start[1] && !ch_busy[1] && sel_isp[1] == 2'h3 // RQ3 RQ8
		|-> ##1 !ch_sample[1] ##1 ch_sample[1])
		else $error("sample point not at two clocks");

	// recovery, counted from the cycle after the last sample
	rec_four_a: assert property (i_io_start[0] && !ch_busy[0] && sel_isp[0] == 2'h0 // RQ6 RQ8
		&& sel_rtc[0] == 2'h0 ##5 i_iordy[0] |=> ch_busy[0] [*4] ##1 !ch_busy[0])
		else $error("primary recovery not four clocks");
	sec_rec_four_a: assert property (i_io_start[1] && !ch_busy[1] && sel_isp[1] == 2'h0 // RQ4
		&& sel_rtc[1] == 2'h0 ##5 i_iordy[1] |=> ch_busy[1] [*4] ##1 !ch_busy[1])
		else $error("secondary recovery not four clocks");
	rec_two_a: assert property (i_io_start[0] && !ch_busy[0] && sel_isp[0] == 2'h2 // RQ6
		&& sel_rtc[0] == 2'h2 ##3 i_iordy[0] |=> ch_busy[0] [*2] ##1 !ch_busy[0])
		else $error("primary recovery not two clocks");
	sec_rec_two_a: assert property (i_io_start[1] && !ch_busy[1] && sel_isp[1] == 2'h2 // RQ4
		&& sel_rtc[1] == 2'h2 ##3 i_iordy[1] |=> ch_busy[1] [*2] ##1 !ch_busy[1])
		else $error("secondary recovery not two clocks");
	rec_one_a: assert property (i_io_start[0] && !ch_busy[0] && sel_isp[0] == 2'h3 // RQ6
		&& sel_rtc[0] == 2'h3 ##2 i_iordy[0] |=> ch_busy[0] ##1 !ch_busy[0])
		else $error("primary recovery not one clock");
	sec_rec_one_a: assert property (i_io_start[1] && !ch_busy[1] && sel_isp[1] == 2'h3 // RQ4
		&& sel_rtc[1] == 2'h3 ##2 i_iordy[1] |=> ch_busy[1] ##1 !ch_busy[1])
		else $error("secondary recovery not one clock");

	// strobe shape and output registers
	wait_ready_a: assert property (ch_sample[0] && !i_iordy[0] // RQ8
		|=> ch_sample[0] && !ch_strobe_n[0])
		else $error("strobe released before ready");
	strobe_busy_a: assert property (!ch_strobe_n[0] |-> ch_busy[0]) // RQ8
		else $error("strobe outside a cycle");
	strobe_busy1_a: assert property (!ch_strobe_n[1] |-> ch_busy[1]) // RQ8
		else $error("secondary strobe outside a cycle");
	sample_strobe_a: assert property (ch_sample[0] |-> !ch_strobe_n[0]) // RQ8
		else $error("sample without strobe");
	sample_strobe1_a: assert property (ch_sample[1] |-> !ch_strobe_n[1]) // RQ8
		else $error("secondary sample without strobe");
	out_regs_a: assert property (1'b1 |=> o_io_strobe_n == $past(ch_strobe_n) // RQ8
		&& o_iordy_sample == $past(ch_sample) && o_busy == $past(ch_busy))
		else $error("channel outputs not registered");

	pri_cycle_c: cover property (i_io_start[0] && !ch_busy[0] ##[1:8] ch_sample[0]);
	sec_slave_c: cover property (use_slave[1] && i_io_start[1] && !ch_busy[1]);
	cfg_write_c: cover property (i_cfg_wr && cfg_hit);
	slow_ready_c: cover property (ch_sample[0] && !i_iordy[0]);
	sec_done_c: cover property (ch_busy[1] ##1 !ch_busy[1]);
endmodule : idst_top
`default_nettype wire

// File: tb/idst_drive_model.sv
// drive model answering the ready line, promptly or after a hold-off
`timescale 1ns/1ns
`default_nettype none
module idst_drive_model (
	input wire logic i_ref_clk,
	input wire logic i_strobe_n,
	input wire logic [3:0] i_wait,
	output logic o_iordy
);
	logic [3:0] cnt_q;
	always_ff @(posedge i_ref_clk) begin
		if (i_strobe_n) cnt_q <= 4'h0;
		else if (cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
	end
	// pulled high whenever the drive is not holding it low
	assign o_iordy = i_strobe_n || (cnt_q >= i_wait);
endmodule : idst_drive_model
`default_nettype wire

// File: tb/idst_top_tb.sv
// self-checking bench for the slave drive timing block
`timescale 1ns/1ns
`default_nettype none
module idst_top_tb;
	import idst_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, cwr = 1'b0, en = 1'b0;
	logic [7:0] ca = 8'h00, cd = 8'h00, rd, wd = 8'h00;
	logic [1:0] pm = 2'h3, st = 2'h0, iw = 2'h0, rdy, stb_n, smp, busy, dsel;
	logic [2:0] ia = 3'h0;
	logic [3:0] wt = 4'h0;
	int mismatches = 0, checks_done = 0, cyc = 0, s, r;
	always #5 clk = ~clk;
	idst_top u_dut (.i_ref_clk(clk), .i_resetn(rstn), .i_cfg_wr(cwr), .i_cfg_addr(ca),
		.i_cfg_wdata(cd), .o_cfg_rdata(rd), .i_separate_slave_timing_enable(en),
		.i_pri_master_isp(pm), .i_pri_master_rtc(pm), .i_sec_master_isp(pm),
		.i_sec_master_rtc(pm), .i_io_start(st), .i_io_write(iw), .i_io_addr(ia),
		.i_io_wdata(wd), .i_iordy(rdy), .o_io_strobe_n(stb_n), .o_iordy_sample(smp),
		.o_busy(busy), .o_drive_sel(dsel));
	idst_drive_model u_drv0 (.i_ref_clk(clk), .i_strobe_n(stb_n[0]), .i_wait(wt), .o_iordy(rdy[0]));
	idst_drive_model u_drv1 (.i_ref_clk(clk), .i_strobe_n(stb_n[1]), .i_wait(wt), .o_iordy(rdy[1]));
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : report_and_stop
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) begin cwr <= 1'b1; ca <= a; cd <= d; end
		@(posedge clk) cwr <= 1'b0;
	endtask : wr
	task rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk) ca <= a;
		@(posedge clk) #1 chk(rd, exp);
	endtask : rdc
	task sel(input logic slave);
		@(posedge clk) begin iw <= 2'h3; ia <= IDST_DRVHEAD_OFS; wd <= {3'h0, slave, 4'h0}; end
		@(posedge clk) iw <= 2'h0;
		@(posedge clk) #1 chk({6'h0, dsel}, {6'h0, slave, slave});
	endtask : sel
	// s: strobe-low cycles up to the first sample; r: busy cycles after it
	task run(input int ch);
		int sm;
		sm = 0; s = 0; r = 0;
		@(posedge clk) st[ch] <= 1'b1;
		@(posedge clk) st <= 2'h0;
		repeat (30) begin
			@(posedge clk) #1;
			if (sm != 0) r += int'(busy[ch] === 1'b1);
			else if (stb_n[ch] === 1'b0) s++;
			if (smp[ch] === 1'b1) sm = 1;
		end
	endtask : run
	task t_regs;
		rdc(IDST_SLAVE_TIMING_OFS, 8'h00);
		wr(IDST_SLAVE_TIMING_OFS, 8'ha5);
		rdc(IDST_SLAVE_TIMING_OFS, 8'ha5);
		wr(8'h45, 8'h3c);
		rdc(8'h45, 8'h00);
		rdc(IDST_SLAVE_TIMING_OFS, 8'ha5);
	endtask : t_regs
	task t_codes;
		logic [1:0] c;
		@(posedge clk) en <= 1'b1;
		sel(1'b1);
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			wr(IDST_SLAVE_TIMING_OFS, {c, c, c, c});
			for (int ch = 0; ch < 2; ch++) begin
				run(ch);
				chk(8'(s), 8'(5 - i));
				chk(8'(r), 8'(4 - i));
			end
		end
	endtask : t_codes
	task t_master;
		wr(IDST_SLAVE_TIMING_OFS, 8'h00);
		en <= 1'b0;
		run(0);
		chk(8'(s), 8'h02);
		chk(8'(r), 8'h01);
		@(posedge clk) en <= 1'b1;
		sel(1'b0);
		run(1);
		chk(8'(s), 8'h02);
		chk(8'(r), 8'h01);
	endtask : t_master
	task t_slow;
		@(posedge clk) wt <= 4'h8;
		run(0);
		chk(8'(s), 8'h02);
		chk({7'h0, r > 4}, 8'h01);
		@(posedge clk) wt <= 4'h0;
	endtask : t_slow
	always @(posedge clk) begin
		cyc++;
		if (cyc >= 20000) begin
			mismatches++;
			report_and_stop();
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_codes();
		t_master();
		t_slow();
		report_and_stop();
	end
endmodule : idst_top_tb
`default_nettype wire
